// *** ssup_pkg.sv ***
// Purpose: constants for the supply supervisor mode-decode block
// Assumes: 20 MHz pclk, APB slave with 32-bit data
// Notes: register offsets are byte addresses
// Overview of operation
// - fast wake-up when low supervisor disabled or full-performance, else slow
// - high supervisor with sleep_keep clear goes off entering deep sleep
// - auto: full-perf high monitor runs normal in deep sleep; manual keeps state
// - check first needs fast wake-up or low monitor off or full-perf, else not affected
// - flag high supervisor: enabled, normal, sleep_keep clear or auto set
// - check result is one when affected, zero when not
// - flag high monitor: enabled, not full-perf, auto set; else not affected
// - wake failure possible within about 1 us of deep sleep entry if affected
package ssup_pkg;
  localparam logic [7:0] ADDR_LOW_CTL = 8'h00;
  localparam logic [7:0] ADDR_HIGH_CTL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_MODE = 8'h14;
  // control register bit positions, same for low and high side
  localparam int B_SUP_EN = 0;
  localparam int B_SUP_KEEP = 1;
  localparam int B_SUP_FP = 2;
  localparam int B_MON_EN = 3;
  localparam int B_MON_FP = 4;
  localparam int B_AUTO = 5;
  localparam int CTL_W = 6;
  localparam logic [5:0] CTL_RESET = 6'h00;
  // irq flag bits
  localparam int I_LOW_SETTLED = 0;
  localparam int I_HIGH_SETTLED = 1;
  localparam int I_HANG_CFG = 2;
  // settling times in ns, cycles derived at the 50 ns period
  localparam int CLK_NS = 50;
  localparam int SETTLE_FAST_NS = 2000;
  localparam int SETTLE_SLOW_NS = 150000;
  localparam int SETTLE_FAST_CYC = (SETTLE_FAST_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_SLOW_CYC = (SETTLE_SLOW_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {SSUP_OFF, SSUP_NORMAL, SSUP_FULL} ssup_state_e;
endpackage // ssup_pkg

// *** ssup_top.sv ***
// Purpose: supply supervisor and monitor mode decode with settle flags
// Assumes: inputs synchronous to pclk; deep_sleep input from the power controller
// Notes: states are reported as 2-bit codes off/normal/full
//
// The register addresses and the APB slave port were chosen for this implementation.
module ssup_top
  import ssup_pkg::*;
#(
  parameter int SETTLE_SLOW = SETTLE_SLOW_CYC, // slow settling count
  parameter int SETTLE_FAST = SETTLE_FAST_CYC  // fast settling count
) (
  input wire logic pclk, // apb clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic deep_sleep, // device in deep sleep modes
  output logic [1:0] low_sup_state, // low supervisor state
  output logic [1:0] low_mon_state, // low monitor state
  output logic [1:0] high_sup_state, // high supervisor state
  output logic [1:0] high_mon_state, // high monitor state
  output logic fast_wake, // fast wake-up selected
  output logic hang_cfg, // wake hang configuration check result
  output logic low_side_settle_flag, // low settling busy
  output logic high_side_settle_flag, // high settling busy
  output logic irq // interrupt, level
);
  logic [CTL_W-1:0] low_side_control_reg;
  logic [CTL_W-1:0] high_side_control_reg;
  logic [2:0] irq_flag;
  logic [2:0] irq_mask;
  logic [17:0] low_cnt;
  logic [17:0] high_cnt;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic next_hang;
  logic next_fast;
  logic hang_rise;
  logic low_done;
  logic high_done;

  // decode one unit: enable, sleep_keep, full_perf, auto, deep sleep
  function automatic ssup_state_e unit_state(input logic en, input logic keep,
      input logic fp, input logic auto_c, input logic sleep);
    ssup_state_e run;
    // plain ifs: a conditional between two enum literals is not typed alike by every tool
    run = SSUP_NORMAL;
    if (fp) run = SSUP_FULL;
    if (!en) return SSUP_OFF;
    if (!sleep) return run;
    if (!keep) return SSUP_OFF;
    if (auto_c) begin
      if (fp) return SSUP_NORMAL;
      return SSUP_OFF;
    end
    return run;
  endfunction

  // settle count in cycles for a side's supervisor performance
  function automatic logic [17:0] settle_len(input logic fp);
    return fp ? 18'(SETTLE_FAST) : 18'(SETTLE_SLOW);
  endfunction

  // apb answers in the access phase with no wait state
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign addr_ok = (paddr == ADDR_LOW_CTL) || (paddr == ADDR_HIGH_CTL) ||
                   (paddr == ADDR_STATUS) || (paddr == ADDR_IRQ_FLAG) ||
                   (paddr == ADDR_IRQ_MASK) || (paddr == ADDR_MODE);
  assign pslverr = psel && penable && !addr_ok;

  // monitors have no sleep_keep bit: they keep running in manual control
  assign low_sup_state = 2'(unit_state(low_side_control_reg[B_SUP_EN],
      low_side_control_reg[B_SUP_KEEP], low_side_control_reg[B_SUP_FP],
      low_side_control_reg[B_AUTO], deep_sleep));
  assign low_mon_state = 2'(unit_state(low_side_control_reg[B_MON_EN], 1'b1,
      low_side_control_reg[B_MON_FP], low_side_control_reg[B_AUTO], deep_sleep));
  assign high_sup_state = 2'(unit_state(high_side_control_reg[B_SUP_EN],
      high_side_control_reg[B_SUP_KEEP], high_side_control_reg[B_SUP_FP],
      high_side_control_reg[B_AUTO], deep_sleep));
  assign high_mon_state = 2'(unit_state(high_side_control_reg[B_MON_EN], 1'b1,
      high_side_control_reg[B_MON_FP], high_side_control_reg[B_AUTO],
      deep_sleep));

  // wake speed and hang check, combinational from control bits
  always_comb begin
    next_fast = !low_side_control_reg[B_SUP_EN] || low_side_control_reg[B_SUP_FP];
    next_hang = 1'b0;
    if (next_fast || !low_side_control_reg[B_MON_EN] ||
        low_side_control_reg[B_MON_FP]) begin
      if (high_side_control_reg[B_SUP_EN] && !high_side_control_reg[B_SUP_FP] &&
          (!high_side_control_reg[B_SUP_KEEP] || high_side_control_reg[B_AUTO]))
        next_hang = 1'b1;
      if (high_side_control_reg[B_MON_EN] && !high_side_control_reg[B_MON_FP] &&
          high_side_control_reg[B_AUTO])
        next_hang = 1'b1;
    end
  end

  // registered status outputs; hang_cfg warns of the ~1 us wake failure window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_wake <= 1'b1;
      hang_cfg <= 1'b0;
    end else begin
      fast_wake <= next_fast;
      hang_cfg <= next_hang;
    end
  end
  assign hang_rise = next_hang && !hang_cfg;

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_side_control_reg <= CTL_RESET;
      high_side_control_reg <= CTL_RESET;
      irq_mask <= 3'h0;
    end else if (wr_en) begin
      if (paddr == ADDR_LOW_CTL) low_side_control_reg <= pwdata[CTL_W-1:0];
      if (paddr == ADDR_HIGH_CTL) high_side_control_reg <= pwdata[CTL_W-1:0];
      if (paddr == ADDR_IRQ_MASK) irq_mask <= pwdata[2:0];
    end
  end

  // settle counters: write restarts, flag stays high until count runs out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= 18'h00000;
      high_cnt <= 18'h00000;
    end else begin
      if (wr_en && paddr == ADDR_LOW_CTL) low_cnt <= settle_len(pwdata[B_SUP_FP]);
      else if (low_cnt != 18'h00000) low_cnt <= low_cnt - 18'h00001;
      if (wr_en && paddr == ADDR_HIGH_CTL) high_cnt <= settle_len(pwdata[B_SUP_FP]);
      else if (high_cnt != 18'h00000) high_cnt <= high_cnt - 18'h00001;
    end
  end
  assign low_side_settle_flag = (low_cnt != 18'h00000);
  assign high_side_settle_flag = (high_cnt != 18'h00000);
  assign low_done = (low_cnt == 18'h00001);
  assign high_done = (high_cnt == 18'h00001);

  // sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag <= 3'h0;
    end else begin
      irq_flag <= (irq_flag & ~((wr_en && paddr == ADDR_IRQ_FLAG) ? pwdata[2:0] : 3'h0))
                  | {hang_rise, high_done, low_done};
    end
  end
  assign irq = |(irq_flag & irq_mask);

  // read data registered in setup so it is valid throughout access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en && !penable) begin
      case (paddr)
        ADDR_LOW_CTL: prdata <= {26'h0, low_side_control_reg};
        ADDR_HIGH_CTL: prdata <= {26'h0, high_side_control_reg};
        ADDR_STATUS: prdata <= {28'h0, hang_cfg, fast_wake, high_side_settle_flag,
                                low_side_settle_flag};
        ADDR_IRQ_FLAG: prdata <= {29'h0, irq_flag};
        ADDR_IRQ_MASK: prdata <= {29'h0, irq_mask};
        ADDR_MODE: prdata <= {24'h0, high_mon_state, high_sup_state, low_mon_state,
                              low_sup_state};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // settle behaviour in two steps: the control write, then the busy stretch after it
  sequence s_low_write;
    wr_en && paddr == ADDR_LOW_CTL;
  endsequence

  sequence s_low_busy;
    low_side_settle_flag [*8];
  endsequence

  property p_settle_hold;
    @(posedge pclk) disable iff (!presetn)
    s_low_write |=> s_low_busy;
  endproperty
  a_settle_hold: assert property (p_settle_hold) else $error("settle flag dropped early");

  // last count with no new write: the flag must fall at once
  property p_settle_end;
    @(posedge pclk) disable iff (!presetn)
    (low_done && !(wr_en && paddr == ADDR_LOW_CTL)) |=> !low_side_settle_flag;
  endproperty
  a_settle_end: assert property (p_settle_end) else $error("settle flag stuck high");

  property p_fast;
    @(posedge pclk) disable iff (!presetn)
    (!low_side_control_reg[B_SUP_EN]) |=> fast_wake;
  endproperty
  a_fast: assert property (p_fast) else $error("fast wake not selected");

  property p_slow;
    @(posedge pclk) disable iff (!presetn)
    (low_side_control_reg[B_SUP_EN] && !low_side_control_reg[B_SUP_FP]) |=> !fast_wake;
  endproperty
  a_slow: assert property (p_slow) else $error("slow wake not selected");

  property p_high_off;
    @(posedge pclk) disable iff (!presetn)
    (deep_sleep && !high_side_control_reg[B_SUP_KEEP]) |-> high_sup_state == 2'(SSUP_OFF);
  endproperty
  a_high_off: assert property (p_high_off) else $error("high supervisor not off");

  property p_mon_auto;
    @(posedge pclk) disable iff (!presetn)
    (deep_sleep && high_side_control_reg[B_MON_EN] && high_side_control_reg[B_MON_FP]
     && high_side_control_reg[B_AUTO]) |-> high_mon_state == 2'(SSUP_NORMAL);
  endproperty
  a_mon_auto: assert property (p_mon_auto) else $error("monitor auto state wrong");

  property p_not_fast_ok;
    @(posedge pclk) disable iff (!presetn)
    (!next_fast && low_side_control_reg[B_MON_EN] && !low_side_control_reg[B_MON_FP])
      |=> !hang_cfg;
  endproperty
  a_not_fast_ok: assert property (p_not_fast_ok) else $error("check flagged slow side");

  property p_sup_hang;
    @(posedge pclk) disable iff (!presetn)
    (next_fast && high_side_control_reg[B_SUP_EN] && !high_side_control_reg[B_SUP_FP]
     && !high_side_control_reg[B_SUP_KEEP]) |=> hang_cfg;
  endproperty
  a_sup_hang: assert property (p_sup_hang) else $error("supervisor hang missed");

  property p_mon_hang;
    @(posedge pclk) disable iff (!presetn)
    (next_fast && high_side_control_reg[B_MON_EN] && !high_side_control_reg[B_MON_FP]
     && high_side_control_reg[B_AUTO]) |=> hang_cfg;
  endproperty
  a_mon_hang: assert property (p_mon_hang) else $error("monitor hang missed");
endmodule // ssup_top

// *** ssup_tb_top.sv ***
// Purpose: self-checking bench for the supply supervisor mode decode
// Assumes: zero-wait apb slave, short settle counts given as parameters
// Notes: expectations come from the state tables, not from the design
module ssup_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ssup_pkg::*;
  localparam int FAST = 10;
  localparam int SLOW = 20;
  logic pclk, presetn, psel, penable, pwrite, deep_sleep, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, fast_wake, hang_cfg, lsf, hsf, irq;
  logic [1:0] ls, lm, hs, hm;
  logic [1:0] ew;
  int n_errors, checks_done;
  logic [5:0] lows [5] = '{6'h00, 6'h01, 6'h19, 6'h09, 6'h27};

  ssup_top #(.SETTLE_SLOW(SLOW), .SETTLE_FAST(FAST)) ssup_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .deep_sleep(deep_sleep), .low_sup_state(ls), .low_mon_state(lm), .high_sup_state(hs),
    .high_mon_state(hm), .fast_wake(fast_wake), .hang_cfg(hang_cfg),
    .low_side_settle_flag(lsf), .high_side_settle_flag(hsf), .irq(irq));

  // 50 ns clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic results();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one apb transfer; read data and error taken at the pready edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      results();
    end
  endtask

  // flags rise on the write edge itself, after xfer has already returned, hence the first wait
  task automatic settle();
    int n;
    n = 0;
    @(posedge pclk);
    while ((lsf || hsf) && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 5000) begin
      n_errors++;
      results();
    end
  endtask

  task automatic measure(input logic [7:0] a, input logic [31:0] d, input bit hi, input int len);
    int n;
    // sampled on the falling edge, where the flag is settled, so the count is exact
    xfer(a, 1'b1, d);
    @(negedge pclk);
    chk("settle start", hi ? hsf : lsf, 32'h1);
    n = 0;
    while ((hi ? hsf : lsf) === 1'b1 && n < 5000) begin
      @(negedge pclk);
      n++;
    end
    chk("settle length", n, len);
  endtask

  // expected state: monitors have no keep bit, so keep reads as one
  function automatic logic [1:0] st(input logic en, keep, fp, au, dp);
    if (!en) return SSUP_OFF;
    if (!dp || (!au && keep)) return fp ? SSUP_FULL : SSUP_NORMAL;
    if (au && keep && fp) return SSUP_NORMAL;
    return SSUP_OFF;
  endfunction

  function automatic logic [7:0] states(input logic [5:0] l, input logic [5:0] h, input logic dp);
    return {st(h[3], 1'b1, h[4], h[5], dp), st(h[0], h[1], h[2], h[5], dp),
            st(l[3], 1'b1, l[4], l[5], dp), st(l[0], l[1], l[2], l[5], dp)};
  endfunction

  function automatic logic hang(input logic [5:0] l, input logic [5:0] h);
    logic q;
    q = !l[0] || l[2] || !l[3] || l[4];
    return q && ((h[0] && !h[2] && (!h[1] || h[5])) || (h[3] && !h[4] && h[5]));
  endfunction

  // main sequence
  initial begin
    {psel, penable, pwrite, deep_sleep, paddr, pwdata} = '0;
    n_errors = 0;
    checks_done = 0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    xfer(ADDR_STATUS, 1'b0, 32'h0);
    chk("status at reset", rd, 32'h4);
    // settle counts, sticky flags, mask and clear
    xfer(ADDR_IRQ_MASK, 1'b1, 32'h0);
    measure(ADDR_LOW_CTL, 32'h4, 1'b0, FAST);
    measure(ADDR_HIGH_CTL, 32'h0, 1'b1, SLOW);
    xfer(ADDR_IRQ_FLAG, 1'b0, 32'h0);
    chk("irq flags", rd, 32'h3);
    chk("irq masked", irq, 32'h0);
    xfer(ADDR_IRQ_MASK, 1'b1, 32'h3);
    @(posedge pclk);
    chk("irq unmasked", irq, 32'h1);
    xfer(ADDR_IRQ_FLAG, 1'b1, 32'h3);
    @(posedge pclk);
    chk("irq cleared", irq, 32'h0);
    xfer(ADDR_IRQ_FLAG, 1'b0, 32'h0);
    chk("flags cleared", rd, 32'h0);
    xfer(8'h18, 1'b0, 32'h0);
    chk("unmapped error", er, 32'h1);
    chk("unmapped data", rd, 32'h0);
    // hang check rising sets its own sticky bit beside the high settle bit
    xfer(ADDR_HIGH_CTL, 1'b1, 32'h1);
    settle();
    xfer(ADDR_IRQ_FLAG, 1'b0, 32'h0);
    chk("hang irq flag", rd, 32'h6);
    xfer(ADDR_IRQ_MASK, 1'b1, 32'h4);
    @(posedge pclk);
    chk("hang irq", irq, 32'h1);
    // every high setting against low settings, awake and in deep sleep
    foreach (lows[i]) begin
      for (int h = 0; h < 64; h++) begin
        xfer(ADDR_LOW_CTL, 1'b1, {26'h0, lows[i]});
        xfer(ADDR_HIGH_CTL, 1'b1, 32'(h));
        settle();
        ew = {hang(lows[i], h[5:0]), !lows[i][0] || lows[i][2]};
        for (int d = 0; d < 2; d++) begin
          deep_sleep <= d[0];
          repeat (2) @(posedge pclk);
          chk("state ports", {hm, hs, lm, ls}, states(lows[i], h[5:0], d[0]));
          xfer(ADDR_MODE, 1'b0, 32'h0);
          chk("state reg", rd, states(lows[i], h[5:0], d[0]));
          xfer(ADDR_STATUS, 1'b0, 32'h0);
          chk("status", rd, {ew, 2'b00});
          chk("wake ports", {hang_cfg, fast_wake}, ew);
        end
        deep_sleep <= 1'b0;
      end
    end
    results();
  end
endmodule // ssup_tb_top
